/* lane_deskew_interface_logic.sv */
// Line transceiver and processor lane logic: word build, clock select, deskew
//
// Notes on behaviour
// - Receive line bits build 16-bit words, first bit in the MSB.
// - Word boundaries ignore any octet alignment in the line stream.
// - Deviation above 1000ppm forwards the reference clock.
// - Out-of-lock is declared above 500ppm, switching to reference.
// - Loss of line signal forwards the reference clock.
// - Clock source alarm is high while the clock is not from data.
// - Source switching never makes a short pulse or period.
// - Receive deskew lane carries frames with samples of the receive lanes.
// - Transmit lanes enter 17 retiming buffers read in parallel each 16 bits.
// - Transmit serialisation sends lane 15 first and lane 0 last.
// - Transmit misalign alarm stays set until all 16 lanes lock.
// - Deskew tracking keeps running after lock.
// - Receive processor buffers 16 lanes plus deskew lane independently.
// - Deskew samples are compared per lane and buffer delay adjusted.
// - Receive misalign alarm held until all 16 lanes lock.
// - Buffer 15 is the earliest bit; the stream is searched for the frame.
// - Transmit processor sends reference frames sampled from its lanes.
// - Persistent mismatch on any lane raises that direction's alarm.
// - Stable skew on every lane clears that direction's alarm.
// - Deskew samples are compared whenever the frame is found, mismatches counted for management.
// - Per-lane fault flags are given beside the direction alarm.
// - Lane rates 2.488 to 3.125 Gb/s; forwarded clocks at a quarter rate.
// - Frame: two F6, two 28, four spare, 1024 samples (64 per lane) lane 15 down.
// - Spare header bytes are 1010 1010, never a framing value.
// - Lane delay moves in one unit interval steps to equalise lanes.
`timescale 1ns/1ps
`default_nettype none
module lane_deskew_interface_logic
    import lane_deskew_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Receive line side (pins)
    input wire logic rxLineBit,
    input wire logic lineSignalLoss,
    input wire logic recoveredClockTick,
    input wire logic [10:0] ppmDeviation,
    // Receive transceiver outputs and lane hold input
    output logic [15:0] rxDataLanes,
    output logic rxDeskewLane,
    output logic rxForwardedClock,
    output logic rxClockSourceAlarm,
    output logic rxBufferReady,
    output logic rxWordOverrun,
    input wire logic rxLanesHold,
    // Transmit transceiver lanes (pins)
    input wire logic [15:0] txDataLanes,
    input wire logic txDeskewLane,
    output logic txLineBit,
    output logic txMisalignAlarm,
    output logic [15:0] txLaneFault,
    output logic txMismatchPulse,
    output logic [15:0] txMismatchCount,
    // Receive processor lanes (pins)
    input wire logic [15:0] rxDataLanesIn,
    input wire logic rxDeskewLaneIn,
    output logic [15:0] rxAlignedWord,
    output logic rxMisalignAlarm,
    output logic [15:0] rxLaneFault,
    output logic rxMismatchPulse,
    output logic [15:0] rxMismatchCount,
    output logic fecFrameFound,
    // Transmit processor side
    input wire logic [15:0] txProcLanes,
    output logic [15:0] txDataLanesOut,
    output logic txDeskewLaneOut
);

    // ----------------------------------------
    // Line bit divider and input synchronisers
    // ----------------------------------------
    logic [3:0] lineCnt_q;
    logic lineS1_q, lineS2_q, losS1_q, losS2_q;
    logic recS1_q, recS2_q, recS3_q;
    logic [1:0][15:0] laneS1_q, laneS2_q;
    logic [1:0] dskS1_q, dskS2_q;
    wire logic laneTick;

    // One lane bit time per 16 line bits
    assign laneTick = (lineCnt_q == LINE_BITS_LAST);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            lineCnt_q <= '0;
        end else begin
            lineCnt_q <= lineCnt_q + 4'h1;
        end
    end

    // Pins cross into clk_sys through two flops each
    always_ff @(posedge clk_sys) begin
        lineS1_q <= rxLineBit;
        lineS2_q <= lineS1_q;
        losS1_q <= lineSignalLoss;
        losS2_q <= losS1_q;
        recS1_q <= recoveredClockTick;
        recS2_q <= recS1_q;
        recS3_q <= recS2_q;
        laneS1_q <= {rxDataLanesIn, txDataLanes};
        laneS2_q <= laneS1_q;
        dskS1_q <= {rxDeskewLaneIn, txDeskewLane};
        dskS2_q <= dskS1_q;
    end

    // ----------------------------------------
    // Receive word build and buffering
    // ----------------------------------------
    logic [15:0] rxAsm_q;
    wire logic [15:0] rxWord;
    wire logic [15:0] fifoOut;
    wire logic fifoInReady, fifoOutValid, fifoPop;

    assign rxWord = {rxAsm_q[14:0], lineS2_q};
    assign fifoPop = laneTick & ~rxLanesHold;

    always_ff @(posedge clk_sys) begin
        rxAsm_q <= rxWord;
    end

    sync_fifo #(.WIDTH(LANES), .DEPTH(8)) rxWordFifo (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .inData(rxWord),
        .inValid(laneTick),
        .inReady(fifoInReady),
        .outData(fifoOut),
        .outValid(fifoOutValid),
        .outReady(fifoPop)
    );

    // Lane outputs hold while the sink stalls; a full buffer drops words
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rxDataLanes <= '0;
            rxBufferReady <= 1'b1;
            rxWordOverrun <= 1'b0;
        end else begin
            rxBufferReady <= fifoInReady;
            if (fifoPop & fifoOutValid) begin
                rxDataLanes <= fifoOut;
            end
            if (laneTick & ~fifoInReady) begin
                rxWordOverrun <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Forwarded receive clock source select
    // ----------------------------------------
    clk_src_e src_q;
    logic [5:0] refCnt_q;
    logic [5:0] halfCnt_q;
    wire logic refTick, recEdge, wantRef, srcTick, canToggle;

    assign wantRef = losS2_q | (ppmDeviation > PPM_OUT_OF_LOCK);
    assign refTick = (refCnt_q == 6'(REF_HALF_CYC - 1));
    assign recEdge = recS2_q & ~recS3_q;
    assign srcTick = (src_q == SRC_REFERENCE) ? refTick : recEdge;
    assign canToggle = (halfCnt_q >= 6'(MIN_PULSE_CYC - 1));

    // switch only while low and after a full minimum width
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            src_q <= SRC_REFERENCE;
            refCnt_q <= '0;
            halfCnt_q <= '0;
            rxForwardedClock <= 1'b0;
        end else begin
            refCnt_q <= refTick ? '0 : refCnt_q + 6'h1;
            if (srcTick & canToggle) begin
                rxForwardedClock <= ~rxForwardedClock;
                halfCnt_q <= '0;
            end else if (!canToggle) begin
                halfCnt_q <= halfCnt_q + 6'h1;
            end
            if (!rxForwardedClock & canToggle) begin
                src_q <= wantRef ? SRC_REFERENCE : SRC_RECOVERED;
            end
        end
    end

    // alarm while clock not from data
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rxClockSourceAlarm <= 1'b1;
        end else begin
            rxClockSourceAlarm <= (src_q == SRC_REFERENCE);
        end
    end

    // ----------------------------------------
    // Reference frame generators (rx transceiver, tx processor)
    // ----------------------------------------
    logic [1:0][10:0] genPos_q;
    wire logic [1:0] genBit;
    wire logic [1:0][15:0] genSrc;

    assign genSrc = {txProcLanes, rxDataLanes};

    for (genvar g = 0; g < DIRS; g++) begin : genFrame
        assign genBit[g] = (genPos_q[g] < HDR_BITS) ? hdrBit(genPos_q[g])
                                                   : genSrc[g][sampleLane(genPos_q[g])];
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            genPos_q <= '0;
            rxDeskewLane <= 1'b0;
            txDeskewLaneOut <= 1'b0;
            txDataLanesOut <= '0;
        end else if (laneTick) begin
            for (int g = 0; g < DIRS; g++) begin
                genPos_q[g] <= (genPos_q[g] == FRAME_LAST_POS) ? '0 : genPos_q[g] + 11'h1;
            end
            rxDeskewLane <= genBit[0];
            txDeskewLaneOut <= genBit[1];
            txDataLanesOut <= txProcLanes;
        end
    end

    // ----------------------------------------
    // Deskew sinks (tx transceiver, rx processor)
    // ----------------------------------------
    logic [1:0][15:0][7:0] hist_q;
    logic [1:0][7:0] dskHist_q;
    logic [1:0][31:0] dskShift_q;
    logic [1:0][10:0] sinkPos_q;
    logic [1:0] framed_q, grpErr_q;
    logic [1:0][15:0][2:0] skew_q;
    logic [1:0][15:0][3:0] goodCnt_q, badCnt_q;
    logic [1:0][15:0] locked_q;
    logic [1:0][15:0] mismatchCnt_q;
    logic [1:0] mismatchPulse_q;
    logic [1:0] dskRef;
    logic [1:0][3:0] curLane;
    logic [1:0] inSample, cmpErr, grpEnd, frameHit;
    logic [1:0][15:0] aligned;

    // per-lane buffers; deskew lane fixed mid tap
    // compare against lane delayed by its skew
    always_comb begin
        for (int d = 0; d < DIRS; d++) begin
            dskRef[d] = dskHist_q[d][DESKEW_REF_TAP];
            curLane[d] = sampleLane(sinkPos_q[d]);
            inSample[d] = framed_q[d] & (sinkPos_q[d] >= HDR_BITS);
            cmpErr[d] = inSample[d] & (dskRef[d] ^ hist_q[d][curLane[d]][skew_q[d][curLane[d]]]);
            grpEnd[d] = laneTick & inSample[d] & (sinkPos_q[d][5:0] == SAMPLE_LAST);
            frameHit[d] = ({dskShift_q[d][30:0], dskRef[d]} == FRAMING_WORD);
            for (int l = 0; l < LANES; l++) begin
                aligned[d][l] = hist_q[d][l][skew_q[d][l]];
            end
        end
    end

    // Histories and frame alignment on the delayed deskew lane
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            hist_q <= '0;
            dskHist_q <= '0;
            dskShift_q <= '0;
            sinkPos_q <= '0;
            framed_q <= '0;
        end else if (laneTick) begin
            for (int d = 0; d < DIRS; d++) begin
                dskHist_q[d] <= {dskHist_q[d][6:0], dskS2_q[d]};
                dskShift_q[d] <= {dskShift_q[d][30:0], dskRef[d]};
                for (int l = 0; l < LANES; l++) begin
                    hist_q[d][l] <= {hist_q[d][l][6:0], laneS2_q[d][l]};
                end
                if (frameHit[d]) begin
                    sinkPos_q[d] <= FRAMING_BITS;
                end else if (sinkPos_q[d] == FRAME_LAST_POS) begin
                    sinkPos_q[d] <= '0;
                end else begin
                    sinkPos_q[d] <= sinkPos_q[d] + 11'h1;
                end
                if (sinkPos_q[d] == FRAMING_LAST_POS) begin
                    framed_q[d] <= frameHit[d];
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            grpErr_q <= '0;
            skew_q <= '0;
            goodCnt_q <= '0;
            badCnt_q <= '0;
            locked_q <= '0;
            mismatchCnt_q <= '0;
            mismatchPulse_q <= '0;
        end else begin
            mismatchPulse_q <= '0;
            for (int d = 0; d < DIRS; d++) begin
                if (laneTick & cmpErr[d] & ~grpEnd[d]) begin
                    grpErr_q[d] <= 1'b1;
                end
                if (grpEnd[d]) begin
                    grpErr_q[d] <= 1'b0;
                    if (grpErr_q[d] | cmpErr[d]) begin
                        mismatchPulse_q[d] <= 1'b1;
                        if (mismatchCnt_q[d] != MISMATCH_MAX) begin
                            mismatchCnt_q[d] <= mismatchCnt_q[d] + 16'h1;
                        end
                        goodCnt_q[d][curLane[d]] <= '0;
                        if (!locked_q[d][curLane[d]] ||
                            badCnt_q[d][curLane[d]] == UNLOCK_FRAMES - 4'h1) begin
                            locked_q[d][curLane[d]] <= 1'b0;
                            badCnt_q[d][curLane[d]] <= '0;
                            skew_q[d][curLane[d]] <= skew_q[d][curLane[d]] + 3'h1;
                        end else begin
                            badCnt_q[d][curLane[d]] <= badCnt_q[d][curLane[d]] + 4'h1;
                        end
                    end else begin
                        badCnt_q[d][curLane[d]] <= '0;
                        if (goodCnt_q[d][curLane[d]] == LOCK_FRAMES - 4'h1) begin
                            locked_q[d][curLane[d]] <= 1'b1;
                        end else begin
                            goodCnt_q[d][curLane[d]] <= goodCnt_q[d][curLane[d]] + 4'h1;
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            txMisalignAlarm <= 1'b1;
            rxMisalignAlarm <= 1'b1;
            txLaneFault <= '1;
            rxLaneFault <= '1;
            txMismatchPulse <= 1'b0;
            rxMismatchPulse <= 1'b0;
            txMismatchCount <= '0;
            rxMismatchCount <= '0;
        end else begin
            txMisalignAlarm <= ~&locked_q[DIR_TXSINK];
            rxMisalignAlarm <= ~&locked_q[DIR_RXSINK];
            txLaneFault <= ~locked_q[DIR_TXSINK];
            rxLaneFault <= ~locked_q[DIR_RXSINK];
            txMismatchPulse <= mismatchPulse_q[DIR_TXSINK];
            rxMismatchPulse <= mismatchPulse_q[DIR_RXSINK];
            txMismatchCount <= mismatchCnt_q[DIR_TXSINK];
            rxMismatchCount <= mismatchCnt_q[DIR_RXSINK];
        end
    end

    // ----------------------------------------
    // Transmit serialiser and receive frame search
    // ----------------------------------------
    logic [15:0] txShift_q;
    logic [15:0] prevWord_q;
    logic fecHit;

    // parallel load each lane time, lane 15 out first
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            txShift_q <= '0;
            txLineBit <= 1'b0;
        end else begin
            txShift_q <= laneTick ? aligned[DIR_TXSINK] : {txShift_q[14:0], 1'b0};
            txLineBit <= txShift_q[15];
        end
    end

    // lane 15 is the earliest bit; search every bit offset
    always_comb begin
        logic [31:0] win;
        win = {prevWord_q, aligned[DIR_RXSINK]};
        fecHit = 1'b0;
        for (int k = 0; k < LANES; k++) begin
            if (win[k +: 16] == FEC_FRAME_PATTERN) begin
                fecHit = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            prevWord_q <= '0;
            rxAlignedWord <= '0;
            fecFrameFound <= 1'b0;
        end else if (laneTick) begin
            prevWord_q <= aligned[DIR_RXSINK];
            rxAlignedWord <= aligned[DIR_RXSINK];
            fecFrameFound <= fecHit & ~rxMisalignAlarm;
        end
    end

endmodule
`default_nettype wire

/* lane_deskew_interface_logic_properties.sv */
// Checker for clock source, alarms and deskew lane timing
`timescale 1ns/1ps
`default_nettype none
module lane_deskew_checker
    import lane_deskew_pkg::*;
(
    // Watched ports
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic lineSignalLoss,
    input wire logic [10:0] ppmDeviation,
    input wire logic rxForwardedClock,
    input wire logic rxClockSourceAlarm,
    input wire logic txMisalignAlarm,
    input wire logic [15:0] txLaneFault,
    input wire logic rxMisalignAlarm,
    input wire logic [15:0] rxLaneFault,
    input wire logic rxMismatchPulse,
    input wire logic [15:0] txMismatchCount,
    input wire logic rxDeskewLane
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic [5:0] runLen_q;
    logic fwdLast_q;
    // Cycles since the clock moved; saturated at reset, so no false short pulse
    always_ff @(posedge clk_sys) begin
        fwdLast_q <= rxForwardedClock;
        if (sys_rst) begin
            runLen_q <= 6'h3F;
        end else if (rxForwardedClock != fwdLast_q) begin
            runLen_q <= 6'h01;
        end else if (runLen_q != 6'h3F) begin
            runLen_q <= runLen_q + 6'h01;
        end
    end
    sequence lossHeld;
        $rose(lineSignalLoss) ##1 lineSignalLoss[*8];
    endsequence
    sequence ppmHigh;
        $rose(ppmDeviation > PPM_SWITCH_MAX) ##1 (ppmDeviation > PPM_SWITCH_MAX)[*8];
    endsequence
    a_loss_forces_ref: assert property (lossHeld |-> ##[0:200] rxClockSourceAlarm)
        else $error("no source alarm on loss");
    a_ppm_forces_ref: assert property (ppmHigh |-> ##[0:200] rxClockSourceAlarm)
        else $error("no source alarm on deviation");
    a_clock_half_width: assert property ($changed(rxForwardedClock) |-> runLen_q >= 6'h1E)
        else $error("forwarded clock pulse short");
    a_tx_alarm_held: assert property ((|txLaneFault)[*3] |-> txMisalignAlarm)
        else $error("tx alarm low while unlocked");
    a_rx_alarm_held: assert property ((|rxLaneFault)[*3] |-> rxMisalignAlarm)
        else $error("rx alarm low while unlocked");
    a_pulse_one_cycle: assert property (rxMismatchPulse |=> !rxMismatchPulse)
        else $error("mismatch pulse too long");
    a_count_never_falls: assert property (1'b1 |=> txMismatchCount >= $past(txMismatchCount))
        else $error("mismatch count fell");
    a_deskew_lane_steps: assert property ($changed(rxDeskewLane) |=> $stable(rxDeskewLane)[*8])
        else $error("deskew lane off lane tick");
endmodule
bind lane_deskew_interface_logic lane_deskew_checker lane_deskew_checker_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .lineSignalLoss(lineSignalLoss),
    .ppmDeviation(ppmDeviation), .rxForwardedClock(rxForwardedClock),
    .rxClockSourceAlarm(rxClockSourceAlarm), .txMisalignAlarm(txMisalignAlarm),
    .txLaneFault(txLaneFault), .rxMisalignAlarm(rxMisalignAlarm),
    .rxLaneFault(rxLaneFault), .rxMismatchPulse(rxMismatchPulse),
    .txMismatchCount(txMismatchCount), .rxDeskewLane(rxDeskewLane)
);
`default_nettype wire

/* lane_deskew_interface_logic_test.sv */
// Bench: word build, clock source selection, alarms and buffer overflow
`timescale 1ns/1ps
`default_nettype none
module lane_deskew_interface_logic_test;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic rxLineBit = 1'b0;
    logic lineSignalLoss = 1'b0;
    logic recoveredClockTick = 1'b0;
    logic [10:0] ppmDeviation = 11'h000;
    logic rxLanesHold = 1'b0;
    logic [15:0] txProcLanes = 16'h0000;
    logic [15:0] srcLanes, rxDataLanes, txLaneFault;
    logic srcDeskew, rxClockSourceAlarm, rxBufferReady, rxWordOverrun;
    logic txMisalignAlarm, rxMisalignAlarm, txDeskewLaneOut;
    logic [15:0] acc = 16'h0000;
    logic [63:0] hdr = 64'h0;
    logic [15:0] notes[$];
    logic [11:0] steps[7] = '{12'h000, 12'h4B0, 12'h000, 12'h258, 12'h032, 12'h800, 12'h000};
    int seed = 90952, nc = 0, fails = 0, nChecks = 0;
    always #2.5 clk_sys = ~clk_sys;
    lane_source_model lane_source_model_i (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .lanes(srcLanes), .deskew(srcDeskew)
    );
    lane_deskew_interface_logic lane_deskew_interface_logic_i (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .rxLineBit(rxLineBit),
        .lineSignalLoss(lineSignalLoss), .recoveredClockTick(recoveredClockTick),
        .ppmDeviation(ppmDeviation), .rxDataLanes(rxDataLanes), .rxDeskewLane(),
        .rxForwardedClock(), .rxClockSourceAlarm(rxClockSourceAlarm),
        .rxBufferReady(rxBufferReady), .rxWordOverrun(rxWordOverrun),
        .rxLanesHold(rxLanesHold), .txDataLanes(srcLanes), .txDeskewLane(srcDeskew),
        .txLineBit(), .txMisalignAlarm(txMisalignAlarm), .txLaneFault(txLaneFault),
        .txMismatchPulse(), .txMismatchCount(), .rxDataLanesIn(srcLanes),
        .rxDeskewLaneIn(srcDeskew), .rxAlignedWord(), .rxMisalignAlarm(rxMisalignAlarm),
        .rxLaneFault(), .rxMismatchPulse(), .rxMismatchCount(), .fecFrameFound(),
        .txProcLanes(txProcLanes), .txDataLanesOut(), .txDeskewLaneOut(txDeskewLaneOut)
    );
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        nChecks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", nChecks, fails);
        if (fails == 0 && nChecks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Inputs move after the falling edge; line bits zero until reset ends
    always @(negedge clk_sys) begin
        nc = nc + 1;
        sys_rst <= nc < 8;
        recoveredClockTick <= nc[5];
        rxLanesHold <= nc >= 800;
        txProcLanes <= 16'($random(seed));
        acc = {acc[14:0], nc >= 8 && 1'($random(seed))};
        rxLineBit <= acc[0];
        if (nc >= 21 && nc % 16 == 5) begin
            notes.push_back(acc);
        end
    end
    // Word in view mid lane period against the oldest note
    always @(posedge clk_sys) begin
        if (nc >= 48 && nc < 800 && nc % 16 == 0 && notes.size() > 0) begin
            check("rxDataLanes", rxDataLanes, notes.pop_front());
        end
        // First frame header, one bit taken mid lane period
        if (nc >= 32 && nc <= 1040 && nc % 16 == 0) begin
            hdr = {hdr[62:0], txDeskewLaneOut};
        end
        if (nc == 1040) begin
            check("txDeskewLaneOut", hdr[63:48], 16'hF6F6);
            check("txDeskewLaneOut", hdr[47:32], 16'h2828);
            check("txDeskewLaneOut", hdr[15:0], 16'hAAAA);
        end
    end
    initial begin
        repeat (20) @(negedge clk_sys);
        check("txLaneFault", txLaneFault, 16'hFFFF);
        check("txMisalignAlarm", 16'(txMisalignAlarm), 16'h0001);
        check("rxMisalignAlarm", 16'(rxMisalignAlarm), 16'h0001);
        foreach (steps[i]) begin
            ppmDeviation = steps[i][10:0];
            lineSignalLoss = steps[i][11];
            repeat (400) @(negedge clk_sys);
            check("rxClockSourceAlarm", 16'(rxClockSourceAlarm),
                16'(steps[i][11] || steps[i][10:0] > 11'h1F4));
        end
        // Held drain fills the buffer; bounded wait for the drop flag
        for (int i = 0; i < 400 && rxWordOverrun !== 1'b1; i++) begin
            @(negedge clk_sys);
        end
        check("rxWordOverrun", 16'(rxWordOverrun), 16'h0001);
        check("rxBufferReady", 16'(rxBufferReady), 16'h0000);
        check("txMisalignAlarm", 16'(txMisalignAlarm), 16'h0001);
        finish_test();
    end
endmodule
`default_nettype wire

/* lane_deskew_pkg.sv */
// Shared constants, frame layout and decode functions for the lane deskew logic
`default_nettype none
package lane_deskew_pkg;

    // ----------------------------------------
    // Lane geometry
    // ----------------------------------------
    localparam int LANES = 16;
    localparam int LANE_W = 4;
    localparam int DIRS = 2;
    localparam int DIR_TXSINK = 0;
    localparam int DIR_RXSINK = 1;
    localparam logic [3:0] LINE_BITS_LAST = 4'hF;

    // ----------------------------------------
    // Reference frame layout (bit positions)
    // ----------------------------------------
    localparam int POS_W = 11;
    localparam logic [10:0] FRAME_LAST_POS = 11'h43F;
    localparam logic [10:0] HDR_BITS = 11'h040;
    localparam logic [10:0] FRAMING_BITS = 11'h020;
    localparam logic [10:0] FRAMING_LAST_POS = 11'h01F;
    localparam logic [5:0] SAMPLE_LAST = 6'h3F;
    localparam logic [7:0] FRAME_BYTE_FIRST = 8'hF6;
    localparam logic [7:0] FRAME_BYTE_SECOND = 8'h28;
    localparam logic [7:0] HEADER_SPARE_BYTE = 8'hAA;
    localparam logic [31:0] FRAMING_WORD = {FRAME_BYTE_FIRST, FRAME_BYTE_FIRST,
                                            FRAME_BYTE_SECOND, FRAME_BYTE_SECOND};

    // ----------------------------------------
    // Skew search and lock qualification
    // ----------------------------------------
    localparam int SKEW_DEPTH = 8;
    localparam int SKEW_W = 3;
    localparam logic [2:0] DESKEW_REF_TAP = 3'h4;
    localparam logic [3:0] LOCK_FRAMES = 4'h4;
    localparam logic [3:0] UNLOCK_FRAMES = 4'h3;
    localparam logic [15:0] MISMATCH_MAX = 16'hFFFF;

    // ----------------------------------------
    // Clock source selection and timing
    // ----------------------------------------
    localparam int SYS_CLK_MHZ = 200;
    localparam int LANE_RATE_MIN_MBPS = 2488;
    localparam int LANE_RATE_MAX_MBPS = 3125;
    localparam int FWD_CLK_RATIO = 4;
    localparam int LINE_PER_LANE = 16;
    localparam int REF_HALF_CYC = LINE_PER_LANE * FWD_CLK_RATIO / 2;
    localparam int MIN_PULSE_NS = 150;
    localparam int MIN_PULSE_CYC = (MIN_PULSE_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam logic [10:0] PPM_LOCK_MIN = 11'h064;
    localparam logic [10:0] PPM_SWITCH_MAX = 11'h3E8;
    localparam logic [10:0] PPM_OUT_OF_LOCK = 11'h1F4;
    localparam logic [15:0] FEC_FRAME_PATTERN = 16'hA5C3;

    typedef enum logic {SRC_RECOVERED, SRC_REFERENCE} clk_src_e;

    // Header bit at a frame position below HDR_BITS, sent MSB first
    function automatic logic hdrBit(input logic [10:0] pos);
        logic [7:0] b;
        b = HEADER_SPARE_BYTE;
        if (pos < FRAMING_BITS) begin
            b = pos[4] ? FRAME_BYTE_SECOND : FRAME_BYTE_FIRST;
        end
        hdrBit = b[3'h7 - pos[2:0]];
    endfunction

    // Lane sampled at a frame position, lane 15 first
    function automatic logic [3:0] sampleLane(input logic [10:0] pos);
        logic [10:0] off;
        off = pos - HDR_BITS;
        sampleLane = 4'hF - off[9:6];
    endfunction

endpackage
`default_nettype wire

/* lane_source_model.sv */
// Far-side source: random data lanes plus reference frames on the deskew lane
`timescale 1ns/1ps
`default_nettype none
module lane_source_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Lanes toward both sinks
    output logic [15:0] lanes,
    output logic deskew
);
    localparam logic [63:0] HEADER = 64'hF6F6_2828_AAAA_AAAA;
    int seed = 90952;
    logic [3:0] bitCnt = 4'h0;
    logic [10:0] pos = 11'h000;
    logic [10:0] off;
    logic [15:0] nextLanes;
    initial begin
        lanes = 16'h0000;
        deskew = 1'b0;
    end
    always @(negedge clk_sys) begin
        bitCnt = sys_rst ? 4'h0 : bitCnt + 4'h1;
        if (sys_rst) begin
            pos = 11'h000;
        end else if (bitCnt == 4'h0) begin
            nextLanes = 16'($random(seed));
            off = pos - 11'h040;
            lanes <= nextLanes;
            deskew <= (pos < 11'h040) ? HEADER[6'(11'h03F - pos)] : nextLanes[4'hF - off[9:6]];
            pos = (pos == 11'h43F) ? 11'h000 : pos + 11'h001;
        end
    end
endmodule
`default_nettype wire

/* sync_fifo.sv */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sync_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Fill side
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    // Drain side
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wrPtr_q;
    logic [PTR_W-1:0] rdPtr_q;
    logic [PTR_W:0] count_q;
    wire logic doWrite;
    wire logic doRead;

    // Handshake decode
    assign inReady = (count_q != (PTR_W+1)'(DEPTH));
    assign outValid = (count_q != '0);
    assign doWrite = inValid & inReady;
    assign doRead = outValid & outReady;
    assign outData = mem[rdPtr_q];

    // Storage, no reset needed on data
    always_ff @(posedge clk_sys) begin
        if (doWrite) begin
            mem[wrPtr_q] <= inData;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (doWrite) begin
                wrPtr_q <= (wrPtr_q == PTR_W'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
            end
            if (doRead) begin
                rdPtr_q <= (rdPtr_q == PTR_W'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
            end
            count_q <= count_q + (PTR_W+1)'(doWrite) - (PTR_W+1)'(doRead);
        end
    end
endmodule
`default_nettype wire
